// ===== verilog/audio_serial_output_port.sv
// How it works
// [R01] Word-clock polarity bit swaps left and right; in TDM the code ignores it and keeps channel order
// [R02] Bit-clock polarity picks data change edge
// [R03] Slave after reset; master bit drives clocks
// [R04] Master bit clock: internal /16 /8 /4 /2
// [R05] Master word clock: /1024 /512 /256
// [R06] Rate fields matter only in master mode
// [R07] Frame sync: square wave or frame pulse
// [R08] TDM: eight channels on first data line
// [R09] MSB first, delayed 1,0,8,12,16 bit clocks
// [R10] Word length 24, 20 or 16 bits
// [R11] Zeros after LSB until next word
// [R12] Software avoids reserved field codes
`timescale 1ns/100ps
`default_nettype none
module audio_serial_output_port #(
  parameter int LINES = audio_out_pkg::NUM_LINES
) (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire logic [audio_out_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [audio_out_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [audio_out_pkg::DATA_W-1:0] reg_rdata,
  input  wire audio_out_pkg::frame_samples_s samples,
  output logic                             samples_taken,
  input  wire logic                        bit_clock_in,
  output logic                             bit_clock_out,
  output logic                             bit_clock_oe,
  input  wire logic                        word_clock_in,
  output logic                             word_clock_out,
  output logic                             word_clock_oe,
  output logic                             serial_data_out_first,
  output logic [LINES-2:0]                 serial_data_out_rest
);
  import audio_out_pkg::*;

  if (LINES != NUM_LINES) begin : g_bad_lines
    $error("Port serves exactly four stereo data lines");
  end

  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] rdata_r;
  port_cfg_s         cfg;
  logic              m_bclk;
  logic              m_wclk;
  logic              bclk_now;
  logic              wclk_now;
  logic              bclk_prev_r;
  logic              wclk_last_r;
  logic              shift_edge;
  logic              frame_start;
  logic [CNT_W-1:0]  bit_cnt_r;
  logic [CNT_W-1:0]  frame_len_r;
  logic [CNT_W-1:0]  slot_len;
  logic [CNT_W-1:0]  slot_pos_r;
  logic [2:0]        slot_idx_r;
  logic [CNT_W-1:0]  pos_nxt;
  logic [2:0]        idx_nxt;
  logic              slot_wrap;
  logic [CNT_W-1:0]  delay_val;
  logic [CNT_W-1:0]  wlen_val;
  logic [CNT_W-1:0]  word_pos;
  logic              in_word;
  logic [4:0]        bit_sel;
  frame_samples_s    held_r;
  frame_samples_s    words;
  logic [LINES-1:0]  line_bit;
  logic [LINES-1:0]  sdo_r;
  logic              ctrl_hit;
  logic              status_hit;
  logic [DATA_W-1:0] rd_mux;

  // Register port
  assign ctrl_hit   = reg_addr == CTRL_ADDR;
  assign status_hit = reg_addr == STATUS_ADDR;
  assign rd_mux     = ctrl_hit   ? ctrl_r :
                      status_hit ? {5'h00, cfg.master, frame_len_r} : '0;
  assign cfg        = port_cfg_s'(ctrl_r[CFG_W-1:0]);
  assign reg_rdata  = rdata_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= CTRL_RESET;                                                  // see [R03]
      rdata_r <= '0;
    end else if (clk_en) begin
      if (reg_wr && ctrl_hit) begin
        ctrl_r <= reg_wdata & CTRL_WMASK;
      end
      rdata_r <= reg_rd ? rd_mux : '0;
    end
  end

  master_clock_divider u_div (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .run     (cfg.master),
    .bdiv    (cfg.bdiv),
    .wdiv    (cfg.wdiv),
    .frame_sync_type     (cfg.frame_sync_type),
    .bclk    (m_bclk),
    .wclk    (m_wclk)
  );

  // Pins are inputs until the master bit is set
  assign bit_clock_out  = m_bclk;
  assign word_clock_out = m_wclk;
  assign bit_clock_oe   = cfg.master;                                         // see [R03]
  assign word_clock_oe  = cfg.master;                                         // see [R03]

  // In slave mode the rate fields are ignored entirely
  assign bclk_now = cfg.master ? m_bclk : bit_clock_in;                       // see [R06]
  assign wclk_now = cfg.master ? m_wclk : word_clock_in;                      // see [R06]

  // Data moves on the falling edge for polarity 0, rising for 1
  assign shift_edge  = clk_en && (bclk_now != bclk_prev_r) &&
                       (bclk_now == cfg.bclk_pol);                            // see [R02]
  // Square clock: frame opens on falling edge; pulse: on its rise
  assign frame_start = shift_edge &&
                       (cfg.frame_sync_type ? (wclk_now & ~wclk_last_r)
                                : (~wclk_now & wclk_last_r));                 // see [R07]
  assign samples_taken = frame_start;

  // Slot length comes from the measured frame, so slave
  // frames split evenly when their bit count is a multiple of the slot count
  assign slot_len  = cfg.tdm ? (frame_len_r >> 3) : (frame_len_r >> 1);      // see [R08]
  assign slot_wrap = slot_pos_r == slot_len - 10'h001;
  assign pos_nxt   = frame_start ? '0 : (slot_wrap ? '0 : slot_pos_r + 10'h001);
  assign idx_nxt   = frame_start ? '0 : (slot_wrap ? slot_idx_r + 3'h1 : slot_idx_r);

  // Reserved codes fall back to the plainest setting
  assign delay_val = (cfg.delay == 3'h0) ? DELAY_CODE0 :
                     (cfg.delay == 3'h1) ? DELAY_CODE1 :
                     (cfg.delay == 3'h2) ? DELAY_CODE2 :
                     (cfg.delay == 3'h3) ? DELAY_CODE3 :
                     (cfg.delay == 3'h4) ? DELAY_CODE4 : DELAY_CODE0;         // see [R09] see [R12]
  assign wlen_val  = (cfg.wlen == 2'h1) ? WLEN_20 :
                     (cfg.wlen == 2'h2) ? WLEN_16 : WLEN_24;                  // see [R10] see [R12]

  assign word_pos = pos_nxt - delay_val;                                      // see [R09]
  assign in_word  = (pos_nxt >= delay_val) && (word_pos < wlen_val) &&
                    (slot_len != '0);                                         // see [R11]
  assign bit_sel  = 5'(SAMPLE_W - 1) - word_pos[4:0];                         // see [R09]

  // A delay of zero needs the new frame's samples on the opening edge
  assign words = frame_start ? samples : held_r;

  for (genvar k = 0; k < LINES; k++) begin : g_line
    logic [2:0] ch;
    logic       live;
    assign ch   = cfg.tdm ? idx_nxt
                          : 3'((2 * k) + {2'b00, idx_nxt[0] ^ cfg.wclk_pol}); // see [R01]
    assign live = cfg.tdm ? (k == 0) : (idx_nxt < 3'h2);                      // see [R08]
    assign line_bit[k] = live && in_word && words.ch[ch][bit_sel];            // see [R11]
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_prev_r <= 1'b0;
      wclk_last_r <= 1'b0;
    end else if (clk_en) begin
      bclk_prev_r <= bclk_now;
      if (shift_edge) begin
        wclk_last_r <= wclk_now;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r   <= '0;
      frame_len_r <= '0;
      slot_pos_r  <= '0;
      slot_idx_r  <= '0;
    end else if (shift_edge) begin
      slot_pos_r <= pos_nxt;
      slot_idx_r <= idx_nxt;
      if (frame_start) begin
        frame_len_r <= bit_cnt_r + 10'h001;
        bit_cnt_r   <= '0;
      end else if (bit_cnt_r != '1) begin
        bit_cnt_r <= bit_cnt_r + 10'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_r <= '0;
      sdo_r  <= '0;
    end else if (shift_edge) begin
      if (frame_start) begin
        held_r <= samples;
      end
      sdo_r <= line_bit;                                                      // see [R02]
    end
  end

  assign serial_data_out_first = sdo_r[0];
  assign serial_data_out_rest  = sdo_r[LINES-1:1];
endmodule // audio_serial_output_port
`default_nettype wire

// ===== verilog/audio_out_pkg.sv
`default_nettype none
package audio_out_pkg;
  // Register map
  localparam int             ADDR_W       = 12;
  localparam int             DATA_W       = 16;
  localparam logic [11:0]    CTRL_ADDR    = 12'h81E;
  localparam logic [11:0]    STATUS_ADDR  = 12'h820;
  localparam logic [15:0]    CTRL_RESET   = 16'h0000;
  localparam logic [15:0]    CTRL_WMASK   = 16'h3FFF;
  localparam int             CFG_W        = 14;

  // Stream shape
  localparam int             SAMPLE_W     = 24;
  localparam int             NUM_CH       = 8;
  localparam int             NUM_LINES    = 4;
  localparam int             CNT_W        = 10;

  // Master divider: bit positions of the 1024-step internal counter
  localparam logic [3:0]     BCLK_BIT_DIV16  = 4'h3;
  localparam logic [3:0]     WCLK_BIT_DIV1024 = 4'h9;
  localparam logic [3:0]     WCLK_BIT_DIV512  = 4'h8;
  localparam logic [3:0]     WCLK_BIT_DIV256  = 4'h7;

  // MSB delay in bit clocks, per code
  localparam logic [9:0]     DELAY_CODE0  = 10'h001;
  localparam logic [9:0]     DELAY_CODE1  = 10'h000;
  localparam logic [9:0]     DELAY_CODE2  = 10'h008;
  localparam logic [9:0]     DELAY_CODE3  = 10'h00C;
  localparam logic [9:0]     DELAY_CODE4  = 10'h010;

  // Word length in bits, per code
  localparam logic [9:0]     WLEN_24      = 10'h018;
  localparam logic [9:0]     WLEN_20      = 10'h014;
  localparam logic [9:0]     WLEN_16      = 10'h010;

  // Control register bits 13..0, MSB first
  typedef struct packed {
    logic       wclk_pol;
    logic       bclk_pol;
    logic       master;
    logic [1:0] bdiv;
    logic [1:0] wdiv;
    logic       frame_sync_type;
    logic       tdm;
    logic [2:0] delay;
    logic [1:0] wlen;
  } port_cfg_s;

  typedef struct packed {
    logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
  } frame_samples_s;
endpackage
`default_nettype wire

// ===== verilog/master_clock_divider.sv
`timescale 1ns/100ps
`default_nettype none
module master_clock_divider (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic [1:0] bdiv,
  input  wire logic [1:0] wdiv,
  input  wire logic       frame_sync_type,
  output logic            bclk,
  output logic            wclk
);
  import audio_out_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [3:0]       bsh;
  logic [3:0]       wsh;
  logic [CNT_W-1:0] wmask;
  logic [CNT_W-1:0] bper;
  logic             pulse;

  assign cnt_nxt = run ? cnt_r + 10'h001 : '0;
  assign bsh     = BCLK_BIT_DIV16 - {2'b00, bdiv};                              // see [R04]
  // Reserved word-clock code falls back to the fastest rate
  assign wsh     = (wdiv == 2'b00) ? WCLK_BIT_DIV1024 :
                   (wdiv == 2'b01) ? WCLK_BIT_DIV512 : WCLK_BIT_DIV256;       // see [R05] see [R12]
  assign wmask   = CNT_W'((11'h002 << wsh) - 11'h001);
  assign bper    = CNT_W'(11'h002 << bsh);
  // Pulse covers the first bit period of each frame
  assign pulse   = (cnt_nxt & wmask) < bper;                                  // see [R07]

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      bclk  <= 1'b0;
      wclk  <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      bclk  <= cnt_nxt[bsh];
      wclk  <= frame_sync_type ? pulse : cnt_nxt[wsh];                                    // see [R07]
    end
  end
endmodule // master_clock_divider
`default_nettype wire

// ===== test/serial_clock_source.sv
`timescale 1ns/100ps
`default_nettype none
module serial_clock_source (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      bclk,
  output logic      wclk
);
  logic [7:0] cnt_r;
  // Far side owns both clocks while the port is slave; idle low between bursts
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= run ? cnt_r + 8'h01 : 8'h00;
    end
  end
  assign bclk = cnt_r[1];
  assign wclk = cnt_r[7];
endmodule // serial_clock_source
`default_nettype wire

// ===== test/audio_serial_output_port_sva.sv
`timescale 1ns/100ps
`default_nettype none
module audio_serial_output_port_sva
  import audio_out_pkg::*;
#(parameter int LINES = NUM_LINES) (
  input wire logic                              sys_clk,
  input wire logic                              rst_n,
  input wire logic                              clk_en,
  input wire logic [audio_out_pkg::ADDR_W-1:0]  reg_addr,
  input wire logic [audio_out_pkg::DATA_W-1:0]  reg_wdata,
  input wire logic                              reg_wr,
  input wire logic                              reg_rd,
  input wire logic [audio_out_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic                              bit_clock_in,
  input wire logic                              bit_clock_out,
  input wire logic                              bit_clock_oe,
  input wire logic                              word_clock_out,
  input wire logic                              word_clock_oe,
  input wire logic                              serial_data_out_first,
  input wire logic [LINES-2:0]                  serial_data_out_rest
);
  import audio_out_pkg::*;
  logic [15:0] ctrl_r;
  logic [10:0] quiet_r, bc_r, wc_r;
  logic        ctrl_wr, sel_bclk, settled;
  assign ctrl_wr  = reg_wr && clk_en && reg_addr == CTRL_ADDR;
  assign sel_bclk = ctrl_r[11] ? bit_clock_out : bit_clock_in;
  // Timing checks wait out the first frames after any reconfiguration
  assign settled  = quiet_r == 11'h7FF;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= CTRL_RESET;
      quiet_r <= 11'h000;
      bc_r    <= 11'h000;
      wc_r    <= 11'h000;
    end else begin
      ctrl_r  <= ctrl_wr ? (reg_wdata & CTRL_WMASK) : ctrl_r;
      quiet_r <= ctrl_wr ? 11'h000 : quiet_r + 11'(!settled);
      bc_r    <= $changed(bit_clock_out) ? 11'h000 : bc_r + 11'h001;
      wc_r    <= $changed(word_clock_out) ? 11'h000 : wc_r + 11'h001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence shift_edge_s;
    $past(sel_bclk) != $past(sel_bclk, 2) && $past(sel_bclk) == ctrl_r[12];
  endsequence
  sequence unmapped_rd_s;
    reg_rd && clk_en && reg_addr != CTRL_ADDR && reg_addr != STATUS_ADDR;
  endsequence
  mode_write_a: assert property (ctrl_wr |=> bit_clock_oe == $past(reg_wdata[11]))
    else $error("clock drive enable does not follow the mode bit");
  oe_pair_a: assert property (bit_clock_oe == word_clock_oe)
    else $error("clock drive enables differ");
  read_back_a: assert property (reg_rd && clk_en && reg_addr == CTRL_ADDR |=> reg_rdata == $past(ctrl_r))
    else $error("control read data wrong");
  idle_zero_a: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_a: assert property (unmapped_rd_s |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  bclk_rate_a: assert property (settled && ctrl_r[11] && $changed(bit_clock_out)
    |-> bc_r + 11'h001 == (11'h008 >> ctrl_r[10:9])) else $error("bit clock half period wrong");
  wclk_rate_a: assert property (settled && ctrl_r[11] && $changed(word_clock_out)
    |-> (ctrl_r[6] ? (word_clock_out || wc_r + 11'h001 == (11'h010 >> ctrl_r[10:9]))
        : wc_r + 11'h001 == (11'h200 >> ctrl_r[8:7]))) else $error("word clock timing wrong");
  tdm_rest_a: assert property (settled && ctrl_r[5] |-> serial_data_out_rest == '0)
    else $error("spare data lines active in TDM");
  shift_edge_a: assert property (settled && $changed(serial_data_out_first) |-> shift_edge_s)
    else $error("data changed away from the shift edge");
endmodule // audio_serial_output_port_sva
bind audio_serial_output_port audio_serial_output_port_sva #(.LINES(LINES)) u_sva (
  .sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bit_clock_in,
  .bit_clock_out, .bit_clock_oe, .word_clock_out, .word_clock_oe, .serial_data_out_first,
  .serial_data_out_rest);
`default_nettype wire

// ===== test/test_audio_serial_output_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_audio_serial_output_port;
  import audio_out_pkg::*;
  logic                 sys_clk, rst_n, clk_en, reg_wr, reg_rd, run, samples_taken;
  logic                 bit_clock_in, bit_clock_out, bit_clock_oe, word_clock_in;
  logic                 word_clock_out, word_clock_oe, serial_data_out_first;
  logic [NUM_LINES-2:0] serial_data_out_rest;
  logic [ADDR_W-1:0]    reg_addr;
  logic [DATA_W-1:0]    reg_wdata, reg_rdata, rd;
  frame_samples_s       samples;
  int                   err_total, checks_done, cycles;
  logic [15:0] cfg [8] = '{16'h0F00, 16'h0D05, 16'h0A0A, 16'h2E8C, 16'h1812, 16'h0E20, 16'h0F40,
                           16'h0700};
  int          per [8] = '{2, 4, 8, 2, 16, 2, 2, 4};
  int          fbits [8] = '{128, 64, 128, 256, 64, 512, 128, 64};
  int          dly [5] = '{1, 0, 8, 12, 16};
  int          wl [3] = '{24, 20, 16};
  audio_serial_output_port DUT (.sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .samples, .samples_taken, .bit_clock_in, .bit_clock_out, .bit_clock_oe,
    .word_clock_in, .word_clock_out, .word_clock_oe, .serial_data_out_first, .serial_data_out_rest);
  serial_clock_source u_far (.sys_clk, .rst_n, .run, .bclk(bit_clock_in), .wclk(word_clock_in));
  task automatic check(string what, logic [511:0] exp, logic [511:0] got);
    checks_done++;
    if (exp !== got) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic reg_write(logic [11:0] a, logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(logic [11:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  function automatic logic [511:0] frame_exp(logic [15:0] c, int fb, int ln);
    logic [511:0] v;
    int slen, off, ch;
    v = '0;
    slen = c[5] ? fb / 8 : fb / 2;
    for (int p = 0; p < fb; p++) begin
      off = p % slen - dly[c[4:2]];
      ch  = c[5] ? p / slen : 2 * ln + ((p / slen) ^ c[13]);
      if (off >= 0 && off < wl[c[1:0]] && !(c[5] && ln > 0)) v[p] = samples.ch[ch][23 - off];
    end
    return v;
  endfunction
  task automatic reg_case();
    reg_read(CTRL_ADDR, rd);
    check("ctrl reset", 16'h0000, rd);
    check("drive enable reset", 1'b0, bit_clock_oe);
    reg_write(CTRL_ADDR, 16'hFEF1);
    reg_read(CTRL_ADDR, rd);
    check("ctrl readback", 16'h3EF1, rd);
    check("drive enable master", 1'b1, bit_clock_oe);
    reg_read(12'h123, rd);
    check("unmapped read", 16'h0000, rd);
    // Frozen port must ignore a write
    clk_en <= 1'b0;
    reg_write(CTRL_ADDR, 16'h0001);
    clk_en <= 1'b1;
    reg_read(CTRL_ADDR, rd);
    check("ctrl frozen", 16'h3EF1, rd);
  endtask
  // Waits long enough for the port to measure a full frame before capturing one
  task automatic stream_case(int i);
    logic [511:0] g0, g1;
    int w;
    g0 = '0;
    g1 = '0;
    w = 0;
    run <= (i == 7);
    reg_write(CTRL_ADDR, cfg[i]);
    repeat (2100) @(posedge sys_clk);
    do @(negedge sys_clk); while (!samples_taken && ++w < 3000);
    check("frame start seen", 1'b1, samples_taken);
    @(posedge sys_clk);
    for (int p = 0; p < fbits[i]; p++) begin
      #1;
      g0[p] = serial_data_out_first;
      g1[p] = serial_data_out_rest[0];
      repeat (per[i]) @(posedge sys_clk);
    end
    check("first line frame", frame_exp(cfg[i], fbits[i], 0), g0);
    check("second line frame", frame_exp(cfg[i], fbits[i], 1), g1);
    reg_read(STATUS_ADDR, rd);
    check("status frame", {5'h00, cfg[i][11], 10'(fbits[i])}, rd);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    run = 1'b0;
    for (int k = 0; k < 8; k++) samples.ch[k] = 24'h8F3C5B + 24'(k) * 24'h111111;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    reg_case();
    for (int i = 0; i < 8; i++) stream_case(i);
    stop_test();
  end
endmodule // test_audio_serial_output_port
`default_nettype wire
